// >>> hdl/pfc_regs.svh
// constants for the synthesizer feature-control and phase detector block
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH
// ------------------------------------------------------------------
// feature register layout
// ------------------------------------------------------------------
`define PFC_FEAT_W 8
`define PFC_FEAT_RST 8'h00
`define PFC_BIT_RSV0 0
`define PFC_BIT_RSV1 1
`define PFC_BIT_FP_OUT 2
`define PFC_BIT_PWR_DOWN 3
`define PFC_BIT_CNT_LOAD 4
`define PFC_BIT_MODSEL_OUT 5
`define PFC_BIT_FC_OUT 6
`define PFC_BIT_LOCK_DIS 7
// ------------------------------------------------------------------
// synchroniser depth
// ------------------------------------------------------------------
`define PFC_SYNC_STAGES 2
`endif

// >>> hdl/pfc_pkg.sv
// types for the synthesizer feature-control block
`default_nettype none
package pfc_pkg;
  // diagnostic output source
  typedef enum logic [1:0] {
    PFC_DIAG_NONE,
    PFC_DIAG_FP,
    PFC_DIAG_MODSEL,
    PFC_DIAG_FC
  } pfc_diag_e;
  // detector state: which edge came first
  typedef enum logic [1:0] {
    PFC_PD_IDLE,
    PFC_PD_DOWN,
    PFC_PD_UP
  } pfc_pd_e;
endpackage
`default_nettype wire

// >>> hdl/pfc_sync.sv
// two-flop synchroniser with rising edge pulse
`default_nettype none
`include "pfc_regs.svh"
module pfc_sync
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  // ------------------------------------------------------------------
  // synchroniser chain
  // ------------------------------------------------------------------
  logic meta_q; // first stage, read only by the second
  logic sync_q; // second stage
  logic prev_q; // previous synced level for edges

  // the first stage is never looked at by anything but sync_q
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;
endmodule // pfc_sync
`default_nettype wire

// >>> hdl/pfc_core.sv
// feature register, phase-frequency detector and lock output
`default_nettype none
`include "pfc_regs.svh"
// Functional notes
// - feature bits active at one, idle at zero
// - bit 2 routes main divider to diagnostic
// - bit 3 powers down all but programming
// - bit 4 loads counter values continuously
// - bit 5 routes modulus select to diagnostic
// - bit 6 routes reference divider to diagnostic
// - bit 7 silences the lock indicator pin
// - detector reacts only to rising edges
// - main leading pulses down_pump_n low
// - reference leading pulses up_pump_n low
// - pulse width follows the phase offset
// - lock node is NAND, indicator is AND
// - features act only while enable low
// - shift eight bits msb first on sclk
// - shadow copied on write strobe falling
module pfc_core
#(
  parameter int FEAT_W = `PFC_FEAT_W
)
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_feat_wr,
  input wire logic i_prim_wr,
  input wire logic i_feature_enable_n,
  input wire logic i_fp,
  input wire logic i_fc,
  input wire logic i_modulus_select_signal,
  output logic o_diag,
  output logic o_power_down,
  output logic o_counter_load,
  output logic o_up_pump_n,
  output logic o_down_pump_n,
  output logic o_lock_node,
  output logic o_lock_indicator_o,
  output logic o_lock_indicator_oe_n
);
  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic sclk_rise; // serial clock rising edge pulse
  logic sdata_s; // synced serial data
  logic fwr_s; // synced feature write strobe
  logic fwr_fall; // feature write strobe falling edge
  logic pwr_s; // synced primary write strobe
  logic fen_n_s; // synced feature enable, active low
  logic fp_rise; // main divider rising edge
  logic fc_rise; // reference divider rising edge
  logic modsel_s; // synced modulus select

  pfc_sync u_sclk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_sclk), .o_level(), .o_rise(sclk_rise), .o_fall());
  pfc_sync u_sdat (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_sdata), .o_level(sdata_s), .o_rise(), .o_fall());
  pfc_sync u_fwr (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_feat_wr), .o_level(fwr_s), .o_rise(),
    .o_fall(fwr_fall));
  pfc_sync u_pwr (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_prim_wr), .o_level(pwr_s), .o_rise(), .o_fall());
  pfc_sync u_fen (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_feature_enable_n), .o_level(fen_n_s), .o_rise(),
    .o_fall());
  pfc_sync u_fp (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_fp), .o_level(), .o_rise(fp_rise), .o_fall());
  pfc_sync u_fc (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_fc), .o_level(), .o_rise(fc_rise), .o_fall());
  pfc_sync u_modsel (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
    .i_async(i_modulus_select_signal), .o_level(modsel_s), .o_rise(),
    .o_fall());

  // ------------------------------------------------------------------
  // serial shift and shadow buffer
  // ------------------------------------------------------------------
  logic [FEAT_W-1:0] shift_q; // serial shift stage
  logic [FEAT_W-1:0] feat_q; // active buffer, write only for software
  logic [FEAT_W-1:0] eff; // bits actually in force
  logic shift_en; // feature write window open

  assign shift_en = fwr_s & ~pwr_s;

  // msb arrives first, so each new bit enters at the bottom
  // power down leaves this path alive so writes still land
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      shift_q <= `PFC_FEAT_RST;
    else if (shift_en && sclk_rise)
      shift_q <= {shift_q[FEAT_W-2:0], sdata_s};
  end

  // the copy waits for the strobe to drop, so a half-shifted
  // pattern never reaches the controls
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      feat_q <= `PFC_FEAT_RST;
    else if (fwr_fall)
      feat_q <= shift_q;
  end

  // enable gates every bit; reserved bits are masked out
  always_comb
  begin
    eff = fen_n_s ? '0 : feat_q;
    eff[`PFC_BIT_RSV0] = 1'b0;
    eff[`PFC_BIT_RSV1] = 1'b0;
  end

  // ------------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------------
  logic pd_act; // power down in force
  assign pd_act = eff[`PFC_BIT_PWR_DOWN];

  // registered so the outputs come from flip-flops
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_power_down <= 1'b0;
      o_counter_load <= 1'b0;
    end
    else
    begin
      o_power_down <= pd_act;
      o_counter_load <= eff[`PFC_BIT_CNT_LOAD];
    end
  end

  // ------------------------------------------------------------------
  // diagnostic output select
  // ------------------------------------------------------------------
  pfc_pkg::pfc_diag_e diag_sel; // chosen source
  logic fp_lvl_q; // main divider phase tracked by edge
  logic fc_lvl_q; // reference divider phase tracked by edge

  // lowest function bit wins when several are set
  always_comb
  begin
    if (eff[`PFC_BIT_FP_OUT])
      diag_sel = pfc_pkg::PFC_DIAG_FP;
    else if (eff[`PFC_BIT_MODSEL_OUT])
      diag_sel = pfc_pkg::PFC_DIAG_MODSEL;
    else if (eff[`PFC_BIT_FC_OUT])
      diag_sel = pfc_pkg::PFC_DIAG_FC;
    else
      diag_sel = pfc_pkg::PFC_DIAG_NONE;
  end

  // divider outputs rebuilt as toggles of their edges
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      fp_lvl_q <= 1'b0;
      fc_lvl_q <= 1'b0;
    end
    else
    begin
      if (fp_rise)
        fp_lvl_q <= ~fp_lvl_q;
      if (fc_rise)
        fc_lvl_q <= ~fc_lvl_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_diag <= 1'b0;
    // power down quiets the pin too; it is not a programming path
    else if (pd_act)
      o_diag <= 1'b0;
    else
    begin
      case (diag_sel)
        pfc_pkg::PFC_DIAG_FP: o_diag <= fp_lvl_q;
        pfc_pkg::PFC_DIAG_MODSEL: o_diag <= modsel_s;
        pfc_pkg::PFC_DIAG_FC: o_diag <= fc_lvl_q;
        default: o_diag <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // phase-frequency detector
  // ------------------------------------------------------------------
  pfc_pkg::pfc_pd_e pd_q; // which pump is running

  // a pump runs from the leading edge to the lagging one, so its
  // width tracks the offset; coincident edges leave both idle
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pd_q <= pfc_pkg::PFC_PD_IDLE;
    else if (pd_act)
      pd_q <= pfc_pkg::PFC_PD_IDLE;
    else
    begin
      case (pd_q)
        pfc_pkg::PFC_PD_IDLE:
        begin
          if (fp_rise && !fc_rise)
            pd_q <= pfc_pkg::PFC_PD_DOWN;
          else if (fc_rise && !fp_rise)
            pd_q <= pfc_pkg::PFC_PD_UP;
        end
        pfc_pkg::PFC_PD_DOWN:
          if (fc_rise)
            pd_q <= pfc_pkg::PFC_PD_IDLE;
        pfc_pkg::PFC_PD_UP:
          if (fp_rise)
            pd_q <= pfc_pkg::PFC_PD_IDLE;
        default:
          pd_q <= pfc_pkg::PFC_PD_IDLE;
      endcase
    end
  end

  assign o_down_pump_n = (pd_q != pfc_pkg::PFC_PD_DOWN);
  assign o_up_pump_n = (pd_q != pfc_pkg::PFC_PD_UP);

  // ------------------------------------------------------------------
  // lock node and open-drain indicator
  // ------------------------------------------------------------------
  logic lock_and; // both pumps idle
  assign lock_and = o_up_pump_n & o_down_pump_n;
  assign o_lock_node = ~lock_and;
  // open drain: pull low when AND is low; released when disabled
  assign o_lock_indicator_o = 1'b0;
  assign o_lock_indicator_oe_n =
    lock_and | eff[`PFC_BIT_LOCK_DIS];

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_pump_excl: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n) !(!o_up_pump_n && !o_down_pump_n))
    else $error("both pumps active");
  a_down_start: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    (pd_q == pfc_pkg::PFC_PD_IDLE && fp_rise && !fc_rise && !pd_act)
    |=> !o_down_pump_n)
    else $error("down pump missed");
  a_up_start: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    (pd_q == pfc_pkg::PFC_PD_IDLE && fc_rise && !fp_rise && !pd_act)
    |=> !o_up_pump_n)
    else $error("up pump missed");
  a_pump_end: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    (!o_down_pump_n && fc_rise) |=> o_down_pump_n)
    else $error("down pump overran");
  a_pump_hold: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    (!o_up_pump_n && !fp_rise && !pd_act) |=> !o_up_pump_n)
    else $error("up pump ended early");
  a_shadow_cap: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n)
    fwr_fall |=> feat_q == $past(shift_q))
    else $error("shadow not captured");
  a_shadow_hold: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n) !fwr_fall |=> $stable(feat_q))
    else $error("shadow changed off strobe");
  a_shift_in: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n) (shift_en && sclk_rise)
    |=> shift_q[0] == $past(sdata_s))
    else $error("serial bit lost");
  a_enable_gate: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n) fen_n_s |=> !o_power_down && !o_counter_load)
    else $error("feature active while disabled");
  a_lock_quiet: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n) eff[`PFC_BIT_LOCK_DIS] |-> o_lock_indicator_oe_n)
    else $error("lock pin not silenced");
  a_pd_idle: assert property (@(posedge i_clk_sys)
    disable iff (!i_arst_n) pd_act |=> o_up_pump_n && o_down_pump_n)
    else $error("pumps run in power down");
  c_down: cover property (@(posedge i_clk_sys) !o_down_pump_n);
  c_up: cover property (@(posedge i_clk_sys) !o_up_pump_n);
  c_write: cover property (@(posedge i_clk_sys) fwr_fall);
  c_diag: cover property (@(posedge i_clk_sys)
    diag_sel == pfc_pkg::PFC_DIAG_MODSEL);
endmodule // pfc_core
`default_nettype wire

// >>> verif/pfc_vco_model.sv
// behavioural loop filter and vco giving the divided feedback edge
`default_nettype none
module pfc_vco_model
(
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_up_pump_n,
  input wire logic i_down_pump_n,
  output logic o_fp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // integrator and divided oscillator
  // ------------------------------------------------------------------
  int per_q; // half period of the divided output, in clocks, less one
  int cnt_q; // clocks spent in the present half period
  // up pulses shorten the period and down pulses stretch it; the clamp
  // keeps edges far enough apart for the detector's synchroniser
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      per_q <= 30;
      cnt_q <= 0;
      o_fp <= 1'b0;
    end
    else
    begin
      if (!i_up_pump_n && per_q > 10)
        per_q <= per_q - 1;
      else if (!i_down_pump_n && per_q < 60)
        per_q <= per_q + 1;
      // half period over: flip the output
      if (cnt_q >= per_q)
      begin
        cnt_q <= 0;
        o_fp <= ~o_fp;
      end
      else
        cnt_q <= cnt_q + 1;
    end
  end
endmodule // pfc_vco_model
`default_nettype wire

// >>> verif/pfc_core_tb.sv
// self-checking bench for the feature register and phase detector
`default_nettype none
module pfc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // stimulus, design and partner
  // ------------------------------------------------------------------
  logic clk = 0, arst_n = 0, sclk = 0, sdata = 0, feat_wr = 0;
  logic prim_wr = 0, en_n = 0, fp_q = 0, fc = 0, mod_sel = 0, fp_sel = 0;
  logic vco_fp, diag, pdn, cld, up_n, dn_n, node, lk_o, lk_oe_n;
  logic [7:0] cur = 8'h00; // last register value accepted
  logic [7:0] rv; // random register value, reserved bits cleared
  int fail_count = 0, total_checks = 0, seed = 76842, cyc = 0, i;
  always #5 clk = ~clk;
  pfc_core uut (.i_clk_sys(clk), .i_arst_n(arst_n), .i_sclk(sclk),
    .i_sdata(sdata), .i_feat_wr(feat_wr), .i_prim_wr(prim_wr),
    .i_feature_enable_n(en_n), .i_fp(fp_sel ? vco_fp : fp_q), .i_fc(fc),
    .i_modulus_select_signal(mod_sel), .o_diag(diag), .o_power_down(pdn),
    .o_counter_load(cld), .o_up_pump_n(up_n), .o_down_pump_n(dn_n),
    .o_lock_node(node), .o_lock_indicator_o(lk_o),
    .o_lock_indicator_oe_n(lk_oe_n));
  pfc_vco_model vco (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_up_pump_n(up_n), .i_down_pump_n(dn_n), .o_fp(vco_fp));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task stop_test;
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bits in force: a high enable masks the whole register
  function logic [7:0] fe(input logic [7:0] v);
    return en_n ? 8'h00 : v;
  endfunction
  // shift a byte msb first; pw high means the write must be ignored
  task wr_feat(input logic [7:0] v, input logic pw);
    int k;
    logic [7:0] e;
    @(posedge clk);
    feat_wr <= 1'b1;
    prim_wr <= pw;
    for (k = 7; k >= 0; k--)
    begin
      tick(4);
      sdata <= v[k];
      tick(4);
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
    end
    tick(6);
    e = fe(cur);
    chk("shadow", {7'h00, pdn}, {7'h00, e[3]});
    feat_wr <= 1'b0;
    prim_wr <= 1'b0;
    if (!pw)
      cur = v;
    tick(8);
    e = fe(cur);
    chk("power_down", {7'h00, pdn}, {7'h00, e[3]});
    chk("counter_load", {7'h00, cld}, {7'h00, e[4]});
  endtask
  // level source on the diagnostic pin; edge sources are counted apart
  // power down must hold the pin low whatever the source
  task dg;
    logic [7:0] e;
    logic xd;
    e = fe(cur);
    if (e[3] || (!e[2] && (e[5] || !e[6])))
    begin
      mod_sel <= 1'($random(seed));
      tick(6);
      xd = e[5] & mod_sel & ~e[3];
      chk("diag", {7'h00, diag}, {7'h00, xd});
    end
  endtask
  // both dividers toggle together so the detector stays idle
  task tog(input logic [7:0] v, input int ex);
    int k, n;
    logic last;
    wr_feat(v, 1'b0);
    n = 0;
    last = diag;
    for (k = 0; k < 48; k++)
    begin
      @(posedge clk);
      if (k % 8 == 0)
        {fp_q, fc} <= {~fp_q, ~fc};
      #1;
      n += (diag !== last);
      last = diag;
    end
    chk("diag_edges", 8'(n), 8'(ex));
  endtask
  // lead edge, lag edge d clocks later, then falls that must do nothing
  task pd(input logic lead_fc, input int d);
    int k, nu, nd, nn, no, p;
    logic [7:0] e;
    {nu, nd, nn, no} = '0;
    e = fe(cur);
    p = e[3] ? 0 : d;
    for (k = 0; k < d + 16; k++)
    begin
      @(posedge clk);
      if (k == (lead_fc ? 0 : d))
        fc <= 1'b1;
      if (k == (lead_fc ? d : 0))
        fp_q <= 1'b1;
      if (k == d + 6)
        {fp_q, fc} <= 2'b00;
      #1;
      nu += (up_n === 1'b0);
      nd += (dn_n === 1'b0);
      nn += (node === 1'b1);
      no += (lk_oe_n === 1'b0);
    end
    chk("up_pump", 8'(nu), 8'(lead_fc ? p : 0));
    chk("down_pump", 8'(nd), 8'(lead_fc ? 0 : p));
    chk("lock_node", 8'(nn), 8'(p));
    chk("lock_pin", 8'(no), 8'(e[7] ? 0 : p));
    chk("lock_data", {7'h00, lk_o}, 8'h00);
  endtask
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      stop_test;
    end
  end
  initial
  begin
    tick(4);
    arst_n <= 1'b1;
    tick(3);
    chk("rst_lock", {7'h00, lk_oe_n}, 8'h01);
    wr_feat(8'h18, 1'b0);
    // deliberate corner: reserved bits set once to show they do nothing
    wr_feat(8'h03, 1'b0);
    wr_feat(8'hff, 1'b1);
    // modulus select source on its own, then under power down
    wr_feat(8'h20, 1'b0);
    dg;
    dg;
    wr_feat(8'h28, 1'b0);
    dg;
    for (i = 0; i < 8; i++)
    begin
      en_n <= 1'($random(seed));
      tick(6);
      rv = 8'($random(seed)) & 8'hfc;
      wr_feat(rv, ($random(seed) % 4) == 0);
      dg;
    end
    en_n <= 1'b0;
    tog(8'h04, 3);
    // main divider outranks modulus select on the pin
    tog(8'h24, 3);
    tog(8'h40, 3);
    tog(8'h00, 0);
    wr_feat(8'h00, 1'b0);
    pd(1'b0, 7);
    pd(1'b1, 3);
    pd(1'b0, 0);
    for (i = 0; i < 6; i++)
      pd(1'($random(seed)), 3 + ($random(seed) & 15));
    wr_feat(8'h80, 1'b0);
    pd(1'b1, 5);
    wr_feat(8'h08, 1'b0);
    pd(1'b0, 9);
    en_n <= 1'b1;
    tick(6);
    pd(1'b1, 4);
    en_n <= 1'b0;
    wr_feat(8'h00, 1'b0);
    fp_sel <= 1'b1;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      if (i % 20 == 0)
        fc <= ~fc;
      #1;
      chk("pumps_excl", {7'h00, up_n | dn_n}, 8'h01);
    end
    stop_test;
  end
endmodule // pfc_core_tb
`default_nettype wire
